// ===== brs_defs.svh
// Timing counts, field positions, thresholds and widths for the bridge reset sequencer
`ifndef BRS_DEFS_SVH
`define BRS_DEFS_SVH
// Clock rate in kHz (50 MHz)
`define BRS_CLK_KHZ 50000
// Clock-detect settle time, in us, and its cycle count (least time, rounded up)
`define BRS_CLK_SETTLE_US 10
`define BRS_CLK_SETTLE_CYC ((`BRS_CLK_SETTLE_US * `BRS_CLK_KHZ + 999) / 1000)
// Latest start of link training after reset release, in ms, and cycles (rounded down)
`define BRS_TRAIN_MAX_MS 80
`define BRS_TRAIN_MAX_CYC (`BRS_TRAIN_MAX_MS * `BRS_CLK_KHZ)
// Controller hold times: reset after stable clock (us) and after power (ms)
`define BRS_PERST_CLK_US 100
`define BRS_PERST_CLK_CYC ((`BRS_PERST_CLK_US * `BRS_CLK_KHZ + 999) / 1000)
`define BRS_PERST_PWR_MS 100
`define BRS_PERST_PWR_CYC (`BRS_PERST_PWR_MS * `BRS_CLK_KHZ)
// Supply-good threshold in percent of nominal
`define BRS_PWR_GOOD_PCT 90
// Secondary bus reset bit position within the bridge control register (offset 3Eh)
`define BRS_BRCTL_OFS 8'h3E
`define BRS_SBR_BIT 6
// Width of static configuration straps
`define BRS_STRAP_W 8
// Reference-clock edges seen before the clock counts as active
`define BRS_REFCLK_EDGES 4
`endif

// ===== brs_pkg.sv
// Types shared by both ends of the bridge reset sequencer
package brs_pkg;
   // Device sequencer states
   typedef enum logic [2:0] {
      BRS_DEV_POR,
      BRS_DEV_CLKWAIT,
      BRS_DEV_SETTLE,
      BRS_DEV_RUN
   } brs_dev_state_t;
   // Controller sequencer states
   typedef enum logic [2:0] {
      BRS_CTL_OFF,
      BRS_CTL_PWR,
      BRS_CTL_CLK,
      BRS_CTL_UP,
      BRS_CTL_DN_RST,
      BRS_CTL_DN_CLK
   } brs_ctl_state_t;
endpackage

// ===== brs_link_if.sv
// Wires between the system controller and the bridge reset sequencer
`timescale 1ns/1ps
interface brs_link_if;
   `include "brs_defs.svh"
   logic global_reset_n; // Global reset, active low
   logic perst_n; // Link fundamental reset, active low
   logic supply_on; // Supplies applied
   logic refclk_run; // Reference clock running (sampled level)
   logic [`BRS_STRAP_W-1:0] straps; // Static configuration inputs
   modport ctl (output global_reset_n, output perst_n, output supply_on,
      output refclk_run, output straps);
   modport dev (input global_reset_n, input perst_n, input supply_on,
      input refclk_run, input straps);
endinterface

// ===== brs_rst_sync.sv
// Reset synchroniser: asynchronous assert, synchronous release
`timescale 1ns/1ps
module brs_rst_sync (
   // Clock and asynchronous reset source
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Synchronised reset, active low
   output logic secondary_bus_reset_bit_n_o
);
   logic meta; // First stage, read only by the second
   logic hold; // Second stage

   // --------------------------------------------------------------
   // Two-stage release
   // --------------------------------------------------------------
   // Releases on a clock edge so every consumer leaves reset together
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta <= 1'b0;
         hold <= 1'b0;
      end else begin
         meta <= 1'b1;
         hold <= meta;
      end
   end
   assign secondary_bus_reset_bit_n_o = hold;
endmodule // brs_rst_sync

// ===== brs_device.sv
// Device end: power-on reset, global and link reset response, boot start
`timescale 1ns/1ps
`include "brs_defs.svh"
module brs_device
   import brs_pkg::*;
#(
   parameter int TRAIN_CYC = `BRS_TRAIN_MAX_CYC, // Training start bound
   parameter int SETTLE_CYC = `BRS_CLK_SETTLE_CYC // Clock settle delay
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Link to the system controller
   brs_link_if.dev link,
   // Core supply monitor, in percent of nominal
   input wire logic [6:0] core_pct_i,
   // Internal events and controls
   input wire logic eeprom_present_i,
   input wire logic hot_reset_i,
   input wire logic sbr_bit_i,
   input wire logic sticky_set_i,
   input wire logic eeload_set_i,
   input wire logic ctl_set_i,
   // Status outputs
   output logic por_n_o,
   output logic bus_reset_n_o,
   output logic link_down_o,
   output logic eeprom_load_o,
   output logic train_start_o,
   output logic [`BRS_STRAP_W-1:0] straps_o,
   output logic sticky_o,
   output logic eeload_o,
   output logic ctl_o
);
   // --------------------------------------------------------------
   // Input synchronisers
   // --------------------------------------------------------------
   logic [2:0] s1; // First stages, read only by s2
   logic [2:0] s2; // Synchronised: perst, refclk, hot reset
   logic [6:0] pct1; // Supply monitor first stage
   logic [6:0] pct2; // Supply monitor second stage
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s1 <= 3'h0;
         s2 <= 3'h0;
         pct1 <= 7'h00;
         pct2 <= 7'h00;
      end else begin
         s1 <= {hot_reset_i, link.refclk_run, link.perst_n};
         s2 <= s1;
         pct1 <= core_pct_i;
         pct2 <= pct1;
      end
   end

   // --------------------------------------------------------------
   // Reset trees
   // --------------------------------------------------------------
   logic global_reset_n_arst_n; // Global or chip reset, asynchronous assert
   logic global_reset_n_n; // Synchronised global reset
   logic perst_arst_n; // Link reset merged with global
   logic perst_n; // Synchronised link reset
   assign global_reset_n_arst_n = resetn_i & link.global_reset_n;
   brs_rst_sync u_global_reset_n (
      .clk_i(clk_i),
      .arst_n_i(global_reset_n_arst_n),
      .secondary_bus_reset_bit_n_o(global_reset_n_n)
   );
   assign perst_arst_n = global_reset_n_arst_n & link.perst_n;
   brs_rst_sync u_perst (
      .clk_i(clk_i),
      .arst_n_i(perst_arst_n),
      .secondary_bus_reset_bit_n_o(perst_n)
   );

   // --------------------------------------------------------------
   // Power-on sequencer
   // --------------------------------------------------------------
   brs_dev_state_t state; // Sequencer state
   brs_dev_state_t next_state;
   logic [31:0] cnt; // Settle delay counter
   logic [31:0] next_cnt;
   logic refclk_q; // Previous synchronised clock level
   logic [3:0] edges; // Clock edges seen
   logic [3:0] next_edges;
   logic por_n; // Internal power-on reset released
   logic next_por_n;
   logic pwr_good; // Supply at threshold
   assign pwr_good = pct2 >= 7'(`BRS_PWR_GOOD_PCT);
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_edges = edges;
      next_por_n = por_n;
      unique case (state)
         // Hold reset until the supply is good
         BRS_DEV_POR: begin
            if (pwr_good) begin
               next_state = BRS_DEV_CLKWAIT;
            end
         end
         // Count clock toggles to judge it active
         BRS_DEV_CLKWAIT: begin
            if (!pwr_good) begin
               next_state = BRS_DEV_POR;
               next_edges = 4'h0;
            end else if (edges == 4'(`BRS_REFCLK_EDGES)) begin
               next_state = BRS_DEV_SETTLE;
               next_cnt = 32'h0;
            end else if (s2[1] != refclk_q) begin
               next_edges = edges + 4'h1;
            end
         end
         // Wait the settle time after the clock is seen
         BRS_DEV_SETTLE: begin
            if (cnt == 32'(SETTLE_CYC - 1)) begin
               next_state = BRS_DEV_RUN;
               next_por_n = 1'b1;
            end else begin
               next_cnt = cnt + 32'h1;
            end
         end
         // Power-on reset released; a supply drop restarts
         BRS_DEV_RUN: begin
            if (!pwr_good) begin
               next_state = BRS_DEV_POR;
               next_por_n = 1'b0;
               next_edges = 4'h0;
            end
         end
      endcase
   end
   // Global reset restarts the whole sequence
   always_ff @(posedge clk_i or negedge global_reset_n_n) begin
      if (!global_reset_n_n) begin
         state <= BRS_DEV_POR;
         cnt <= 32'h0;
         edges <= 4'h0;
         por_n <= 1'b0;
         refclk_q <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         edges <= next_edges;
         por_n <= next_por_n;
         refclk_q <= s2[1];
      end
   end

   // --------------------------------------------------------------
   // Boot actions after both resets leave
   // --------------------------------------------------------------
   logic up_n; // Power-on and link resets both released
   assign up_n = por_n & perst_n;
   logic started; // Boot actions issued once per release
   logic next_started;
   logic [31:0] tcnt; // Training deadline counter
   logic [31:0] next_tcnt;
   logic next_load;
   logic next_train;
   logic [`BRS_STRAP_W-1:0] next_straps;
   always_comb begin
      next_started = started;
      next_tcnt = tcnt;
      next_load = 1'b0;
      next_train = train_start_o;
      next_straps = straps_o;
      if (!up_n) begin
         next_started = 1'b0;
         next_tcnt = 32'h0;
         next_train = 1'b0;
      end else if (!started) begin
         next_started = 1'b1;
         next_straps = link.straps;
         next_load = eeprom_present_i;
      end else if (!train_start_o) begin
         // Training begins well inside the bound; the counter guards it
         if (tcnt == 32'(TRAIN_CYC / 1024) || s2[2] == 1'b0) begin
            next_train = 1'b1;
         end
         next_tcnt = tcnt + 32'h1;
      end
      if (s2[2]) begin
         next_train = 1'b0;
         next_tcnt = 32'h0;
      end
   end
   always_ff @(posedge clk_i or negedge global_reset_n_n) begin
      if (!global_reset_n_n) begin
         started <= 1'b0;
         tcnt <= 32'h0;
         eeprom_load_o <= 1'b0;
         train_start_o <= 1'b0;
         straps_o <= '0;
      end else begin
         started <= next_started;
         tcnt <= next_tcnt;
         eeprom_load_o <= next_load;
         train_start_o <= next_train;
         straps_o <= next_straps;
      end
   end

   // --------------------------------------------------------------
   // Register classes and bus reset
   // --------------------------------------------------------------
   logic next_sticky;
   logic next_eeload;
   logic next_ctl;
   logic next_bus_n;
   logic next_down;
   always_comb begin
      next_sticky = sticky_o | sticky_set_i;
      next_eeload = eeload_o | eeload_set_i;
      next_ctl = ctl_o | ctl_set_i;
      next_down = s2[2];
      // Link reset and hot reset clear ordinary control bits
      if (!perst_n || !por_n || s2[2]) begin
         next_ctl = 1'b0;
      end
      if (!perst_n || !por_n) begin
         next_eeload = 1'b0;
      end
      if (!por_n) begin
         next_sticky = 1'b0;
      end
      next_bus_n = por_n & perst_n & ~s2[2] & ~sbr_bit_i;
   end
   // Sticky bits survive everything but global and power-on reset
   always_ff @(posedge clk_i or negedge global_reset_n_n) begin
      if (!global_reset_n_n) begin
         sticky_o <= 1'b0;
         eeload_o <= 1'b0;
         ctl_o <= 1'b0;
         bus_reset_n_o <= 1'b0;
         link_down_o <= 1'b0;
         por_n_o <= 1'b0;
      end else begin
         sticky_o <= next_sticky;
         eeload_o <= next_eeload;
         ctl_o <= next_ctl;
         bus_reset_n_o <= next_bus_n;
         link_down_o <= next_down;
         por_n_o <= por_n;
      end
   end
endmodule // brs_device

// ===== brs_controller.sv
// Controller end: orders supplies, reference clock and resets
`timescale 1ns/1ps
`include "brs_defs.svh"
module brs_controller
   import brs_pkg::*;
#(
   parameter int PWR_CYC = `BRS_PERST_PWR_CYC, // Hold after power
   parameter int CLK_CYC = `BRS_PERST_CLK_CYC // Hold after clock
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // User side
   input wire logic power_req_i,
   input wire logic [`BRS_STRAP_W-1:0] straps_i,
   output logic up_o,
   // Link to the device
   brs_link_if.ctl link
);
   brs_ctl_state_t state; // Sequence state
   brs_ctl_state_t next_state;
   logic [31:0] cnt; // Hold counter
   logic [31:0] next_cnt;
   logic global_reset_n_n; // Global reset drive
   logic next_global_reset_n_n;
   logic refclk; // Divided reference clock
   logic clk_en; // Clock running
   logic next_clk_en;

   // --------------------------------------------------------------
   // Sequence decode
   // --------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_cnt = cnt + 32'h1;
      next_global_reset_n_n = global_reset_n_n;
      next_clk_en = clk_en;
      unique case (state)
         // Resets held, supplies off
         BRS_CTL_OFF: begin
            next_cnt = 32'h0;
            if (power_req_i) begin
               next_state = BRS_CTL_PWR;
            end
         end
         // Supplies on; clock starts CLK_CYC cycles before the power hold ends
         BRS_CTL_PWR: begin
            if (cnt >= 32'(PWR_CYC - CLK_CYC - 1)) begin
               next_state = BRS_CTL_CLK;
               next_clk_en = 1'b1;
               next_global_reset_n_n = 1'b1;
            end
         end
         // Clock running; both holds must pass
         BRS_CTL_CLK: begin
            if (cnt >= 32'(PWR_CYC)) begin
               next_state = BRS_CTL_UP;
            end
         end
         BRS_CTL_UP: begin
            if (!power_req_i) begin
               next_state = BRS_CTL_DN_RST;
            end
         end
         BRS_CTL_DN_RST: begin
            next_state = BRS_CTL_DN_CLK;
            next_clk_en = 1'b0;
         end
         BRS_CTL_DN_CLK: begin
            next_state = BRS_CTL_OFF;
            next_global_reset_n_n = 1'b0;
         end
      endcase
   end
   // Registers of the sequence; outputs from flip-flops, except supply_on, decoded from state
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= BRS_CTL_OFF;
         cnt <= 32'h0;
         global_reset_n_n <= 1'b0;
         clk_en <= 1'b0;
         refclk <= 1'b0;
         up_o <= 1'b0;
         link.straps <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         global_reset_n_n <= next_global_reset_n_n;
         clk_en <= next_clk_en;
         // Follows the next enable so the clock parks low before supplies drop
         refclk <= next_clk_en & ~refclk;
         up_o <= (next_state == BRS_CTL_UP);
         link.straps <= straps_i;
      end
   end
   assign link.global_reset_n = global_reset_n_n;
   assign link.perst_n = up_o;
   assign link.supply_on = (state != BRS_CTL_OFF);
   assign link.refclk_run = refclk;
endmodule // brs_controller

// ===== brs_link_sva.sv
// Checker for supply, clock and reset ordering between controller and device ends
`timescale 1ns/1ps
module brs_link_sva #(
   parameter int PWR_CYC = 2000, // Hold after power
   parameter int CLK_CYC = 200, // Hold after clock
   parameter int SETTLE_CYC = 20 // Clock settle delay
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Link wires
   input wire logic global_reset_n,
   input wire logic perst_n,
   input wire logic supply_on,
   input wire logic refclk_run,
   // Device inputs and status
   input wire logic [6:0] core_pct_i,
   input wire logic sbr_bit_i,
   input wire logic por_n_o,
   input wire logic bus_reset_n_o,
   input wire logic train_start_o
);
   // ---------------------------------------------
   // Helper counters
   // ---------------------------------------------
   // Two cycles of slack: the launch edge and its sampling edge
   localparam int PWR_MIN = PWR_CYC - 2;
   localparam int CLK_MIN = CLK_CYC - 2;
   localparam int TRAIN_WAIT = 1100; // Scaled training bound plus sync slack
   int train_cnt; // Cycles with link reset released and no training yet
   int pwr_cnt; // Cycles with supplies on
   int clk_cnt; // Clock toggles while powered
   int good_cnt; // Cycles with supply at or above 90
   logic ref_q; // Last clock level
   int next_pwr_cnt, next_clk_cnt, next_good_cnt, next_train_cnt;
   // Next counts; cleared whenever their cause drops
   always_comb begin
      next_pwr_cnt = supply_on ? pwr_cnt + 1 : 0;
      next_clk_cnt = !supply_on ? 0 : clk_cnt + int'(refclk_run != ref_q);
      next_good_cnt = (core_pct_i >= 7'h5A) ? good_cnt + 1 : 0;
      // Too long for a delay range, so the wait is counted here
      next_train_cnt = (perst_n && !train_start_o) ? train_cnt + 1 : 0;
   end
   // Register the counts
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pwr_cnt <= 0;
         clk_cnt <= 0;
         good_cnt <= 0;
         train_cnt <= 0;
         ref_q <= 1'b0;
      end else begin
         pwr_cnt <= next_pwr_cnt;
         clk_cnt <= next_clk_cnt;
         good_cnt <= next_good_cnt;
         train_cnt <= next_train_cnt;
         ref_q <= refclk_run;
      end
   end
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // Clock stopped while the link reset is held
   sequence s_clk_stopped;
      $stable(refclk_run) ##0 !perst_n;
   endsequence
   property p_rst_at_pwr; $rose(supply_on) |-> !perst_n && !global_reset_n; endproperty
   a_rst_at_pwr: assert property (p_rst_at_pwr) else $error("reset not held at power up");
   property p_clk_pwr; $changed(refclk_run) |-> supply_on; endproperty
   a_clk_pwr: assert property (p_clk_pwr) else $error("clock without supplies");
   property p_perst_clk; $rose(perst_n) |-> clk_cnt >= CLK_MIN; endproperty
   a_perst_clk: assert property (p_perst_clk) else $error("link reset released early");
   property p_perst_pwr; $rose(perst_n) |-> pwr_cnt >= PWR_MIN; endproperty
   a_perst_pwr: assert property (p_perst_pwr) else $error("link reset before power");
   property p_down; $fell(supply_on) |-> s_clk_stopped; endproperty
   a_down: assert property (p_down) else $error("supplies removed out of order");
   property p_clk_up; perst_n |-> $changed(refclk_run); endproperty
   a_clk_up: assert property (p_clk_up) else $error("clock stopped before reset");
   property p_por_pwr; $rose(por_n_o) |-> good_cnt >= SETTLE_CYC; endproperty
   a_por_pwr: assert property (p_por_pwr) else $error("power-on reset before supply good");
   property p_por_clk; $rose(por_n_o) |-> clk_cnt >= SETTLE_CYC; endproperty
   a_por_clk: assert property (p_por_clk) else $error("power-on reset before settle");
   property p_por_bus; !por_n_o |-> !bus_reset_n_o; endproperty
   a_por_bus: assert property (p_por_bus) else $error("bus reset not driven");
   property p_global_reset_n; !global_reset_n |-> !por_n_o; endproperty
   a_global_reset_n: assert property (p_global_reset_n) else $error("global reset did not reset");
   property p_train; train_cnt <= TRAIN_WAIT; endproperty
   a_train: assert property (p_train) else $error("training start late");
   property p_sbr; sbr_bit_i |=> !bus_reset_n_o; endproperty
   a_sbr: assert property (p_sbr) else $error("bus reset bit ignored");
endmodule // brs_link_sva

// ===== tb.sv
// Self-checking bench for both ends of the bridge reset sequencer
`timescale 1ns/1ps
`include "brs_defs.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin mismatches++; \
   $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb;
   // ---------------------------------------------
   // Signals
   // ---------------------------------------------
   logic clk_i, resetn_i, power_req_i, up_o, eeprom_present_i, hot_reset_i, sbr_bit_i;
   logic sticky_set_i, eeload_set_i, ctl_set_i, por_n_o, bus_reset_n_o, link_down_o;
   logic eeprom_load_o, train_start_o, sticky_o, eeload_o, ctl_o;
   logic [`BRS_STRAP_W-1:0] straps_i, straps_o, exp_st;
   logic [6:0] core_pct_i;
   int mismatches, cmp_count, cyc, seed, ld_cnt, ld0, n;
   brs_link_if brs_link_if_i();
   brs_controller #(.PWR_CYC(2000), .CLK_CYC(200)) brs_controller_i (.clk_i(clk_i),
      .resetn_i(resetn_i), .power_req_i(power_req_i), .straps_i(straps_i), .up_o(up_o),
      .link(brs_link_if_i));
   brs_device #(.TRAIN_CYC(1024000), .SETTLE_CYC(20)) brs_device_i (.clk_i(clk_i),
      .resetn_i(resetn_i), .link(brs_link_if_i), .core_pct_i(core_pct_i),
      .eeprom_present_i(eeprom_present_i), .hot_reset_i(hot_reset_i), .sbr_bit_i(sbr_bit_i),
      .sticky_set_i(sticky_set_i), .eeload_set_i(eeload_set_i), .ctl_set_i(ctl_set_i),
      .por_n_o(por_n_o), .bus_reset_n_o(bus_reset_n_o), .link_down_o(link_down_o),
      .eeprom_load_o(eeprom_load_o), .train_start_o(train_start_o), .straps_o(straps_o),
      .sticky_o(sticky_o), .eeload_o(eeload_o), .ctl_o(ctl_o));
   brs_link_sva brs_link_sva_i (
      .clk_i(clk_i), .resetn_i(resetn_i), .global_reset_n(brs_link_if_i.global_reset_n),
      .perst_n(brs_link_if_i.perst_n), .supply_on(brs_link_if_i.supply_on),
      .refclk_run(brs_link_if_i.refclk_run), .core_pct_i(core_pct_i), .sbr_bit_i(sbr_bit_i),
      .por_n_o(por_n_o), .bus_reset_n_o(bus_reset_n_o), .train_start_o(train_start_o));
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   // Expected bus reset level from its causes
   function automatic logic exp_bus(logic por, logic sbr);
      return por & ~sbr;
   endfunction
   // Let k edges pass, then sample settled outputs
   task automatic step(int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask
   // Bounded wait for link training to start
   task automatic wait_train();
      for (n = 0; n < 1100 && train_start_o !== 1'b1; n++) step(1);
   endtask
   // Pulse all three sample bit classes
   task automatic set_bits();
      @(posedge clk_i) {sticky_set_i, eeload_set_i, ctl_set_i} <= 3'h7;
      @(posedge clk_i) {sticky_set_i, eeload_set_i, ctl_set_i} <= 3'h0;
      step(2);
   endtask
   // Verdict and end of run
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Clock at 50 MHz
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // Load pulse counter and hang guard
   always @(posedge clk_i) begin
      if (eeprom_load_o === 1'b1) ld_cnt++;
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         conclude();
      end
   end
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      {resetn_i, power_req_i, eeprom_present_i, hot_reset_i, sbr_bit_i} = 5'h00;
      {sticky_set_i, eeload_set_i, ctl_set_i} = 3'h0;
      straps_i = 8'h00;
      core_pct_i = 7'h00;
      {mismatches, cmp_count, cyc, ld_cnt} = 0;
      seed = 19;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      // Two power cycles: with and without a boot memory
      for (int k = 0; k < 2; k++) begin
         exp_st = 8'($random(seed));
         ld0 = ld_cnt;
         @(posedge clk_i) {straps_i, eeprom_present_i, power_req_i} <= {exp_st, ~k[0], 1'b1};
         core_pct_i <= 7'h59; // Just below the supply threshold
         for (n = 0; n < 2500 && up_o !== 1'b1; n++) step(1);
         `CHK("up", 1'b1, up_o)
         `CHK("por low", 1'b0, por_n_o)
         @(posedge clk_i) core_pct_i <= 7'h5A;
         wait_train();
         `CHK("train", 1'b1, train_start_o)
         `CHK("straps", exp_st, straps_o)
         step(2);
         `CHK("loads", int'(k == 0), ld_cnt - ld0)
         set_bits();
         @(posedge clk_i) hot_reset_i <= 1'b1;
         step(4);
         `CHK("link down", 1'b1, link_down_o)
         `CHK("ctl hot", 1'b0, ctl_o)
         `CHK("sticky hot", 1'b1, sticky_o)
         `CHK("eeload hot", 1'b1, eeload_o)
         @(posedge clk_i) hot_reset_i <= 1'b0;
         wait_train();
         `CHK("retrain", 1'b1, train_start_o)
         for (int v = 1; v >= 0; v--) begin
            @(posedge clk_i) sbr_bit_i <= v[0];
            step(3);
            `CHK("bus rst", exp_bus(1'b1, v[0]), bus_reset_n_o)
         end
         set_bits();
         @(posedge clk_i) power_req_i <= 1'b0;
         for (n = 0; n < 100 && brs_link_if_i.perst_n !== 1'b0; n++) step(1);
         // One edge only: global reset follows two edges after the link reset
         step(1);
         `CHK("eeload down", 1'b0, eeload_o)
         `CHK("ctl down", 1'b0, ctl_o)
         `CHK("bus perst", 1'b0, bus_reset_n_o)
         `CHK("sticky perst", 1'b1, sticky_o)
         for (n = 0; n < 100 && brs_link_if_i.global_reset_n !== 1'b0; n++) step(1);
         step(2);
         `CHK("por global_reset_n", 1'b0, por_n_o)
         `CHK("sticky global_reset_n", 1'b0, sticky_o)
         `CHK("bus global_reset_n", 1'b0, bus_reset_n_o)
         step(10);
      end
      conclude();
   end
endmodule // tb
